// File: design/sar_regs.svh
// Constants for the converter control block: timing counts and code layout.
// Assumes a 40 MHz core clock that stands in for the internal oscillator.
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH

// Core clock period in nanoseconds.
`define SAR_CORE_NS      25
// Typical acquisition time in nanoseconds.
`define SAR_ACQ_NS       1120
// Typical conversion time in nanoseconds.
`define SAR_CONV_NS      8960
// Acquisition cycles, rounded up: 45.
`define SAR_ACQ_CYC      ((`SAR_ACQ_NS + `SAR_CORE_NS - 1) / `SAR_CORE_NS)
// Cycles per decided bit, rounded down so ten bits fit the time: 35.
`define SAR_BIT_CYC      (`SAR_CONV_NS / `SAR_CORE_NS / `SAR_RES_W)
// Result width in bits.
`define SAR_RES_W        10
// Serial clocks per conversion in continuous mode.
`define SAR_CLKS_PER_CNV 18
// Leading zero bits in the upper result byte.
`define SAR_PAD_W        4
// Position of the read/write bit in the address byte.
`define SAR_RW_POS       0

`endif

// File: design/sar_pkg.sv
// Types shared by the converter control block.
// Assumes the constants header sits in the include path.
`include "sar_regs.svh"

package sar_pkg;

   // Converter sequencer states.
   typedef enum logic [1:0] {CS_IDLE, CS_ACQ, CS_CONV} sar_core_st_t;

   // Two-wire slave states.
   typedef enum logic [2:0] {
      LS_IDLE, LS_ADDR, LS_AACK, LS_TX, LS_MACK, LS_WAIT
   } sar_link_st_t;

   // Drive to the analog front end: track switch and trial code.
   typedef struct packed {
      logic                  track;
      logic [`SAR_RES_W-1:0] dac;
   } sar_afe_t;

   // All state of the oscillator-side sequencer.
   typedef struct packed {
      sar_core_st_t          st;
      logic [5:0]            cnt;
      logic [3:0]            bitn;
      logic [`SAR_RES_W-1:0] sar;
      logic [`SAR_RES_W-1:0] result;
      logic                  done_tgl;
      logic                  pend;
      logic                  req_s1;
      logic                  req_s2;
      logic                  req_s3;
      logic                  cmp_s1;
      logic                  cmp_s2;
   } sar_core_state_t;

   // All state of the link-side slave.
   typedef struct packed {
      sar_link_st_t          st;
      logic                  scl_s1;
      logic                  scl_s2;
      logic                  scl_s3;
      logic                  sda_s1;
      logic                  sda_s2;
      logic                  sda_s3;
      logic                  dn_s1;
      logic                  dn_s2;
      logic                  dn_s3;
      logic [3:0]            cnt;
      logic [7:0]            sh;
      logic                  rw;
      logic                  byte1;
      logic                  oe_n;
      logic                  req_tgl;
      logic [`SAR_RES_W-1:0] res;
   } sar_link_state_t;

endpackage

// File: design/sar_adc_i2c_readout.sv
// Digital control of a 10-bit successive-approximation converter with a
// two-wire slave readout. The sequencer runs on core_clk, which plays the
// internal oscillator; the slave runs on link_clk and oversamples the pins.
// Assumes an external comparator and trial DAC, and pull-ups on both wires.
`timescale 1ns/1ps
`include "sar_regs.svh"

// Behaviour
// - Data line changes only while clock low.
// - Data edge with clock high is start/stop.
// - Finished result kept in 10-bit holding register.
// - Input held, then ten bits decided serially.
// - Conversion self-timed, about 8.96 us.
// - Acquisition self-timed, about 1.12 us.
// - Result sent MSB first, straight binary.
// - Master ack after result continues converting.
// - Continuous mode uses 18 serial clocks.
// - Sustains 22.2 ksps at 400 kHz; here the ack clock must be stretched for that.
// - Matching read address acknowledged, starts conversion.
// - Matching write address acknowledged, then released.
// - Four zeros, bits 9..6, ack, 5..0, two pad.
// - Next sample starts at last bit's falling edge.
module sar_adc_i2c_readout #(
   parameter logic [3:0] DEV_CODE = 4'h5, // Arbitrary device code value.
   parameter logic [2:0] DEV_ADDR = 3'h0  // Arbitrary address bits value.
) (
   input  wire logic            core_clk,
   input  wire logic            rst_n,
   input  wire logic            link_clk,
   input  wire logic            scl_i,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe_n,
   input  wire logic            cmp_in,
   output sar_pkg::sar_afe_t    afe
);
   import sar_pkg::*;

   localparam int ACQ_C  = `SAR_ACQ_CYC;
   localparam int CONV_C = `SAR_BIT_CYC * `SAR_RES_W;
   // Cycles from the eighth tracking cycle to the first one not tracking.
   localparam int ACQ_TAIL = ACQ_C - 7;

   sar_core_state_t c_ff;     // Sequencer state.
   sar_core_state_t nxt_c;    // Its next value.
   sar_link_state_t l_ff;     // Slave state.
   sar_link_state_t nxt_l;    // Its next value.

   // Sequencer: waits for a request, tracks, then decides ten bits.
   // A request that lands while busy is remembered, not dropped.
   always_comb begin
      logic req;
      req = 1'b0;
      nxt_c = c_ff;
      // The first stage of each synchroniser feeds only the second.
      nxt_c.req_s1 = l_ff.req_tgl;
      nxt_c.req_s2 = c_ff.req_s1;
      nxt_c.req_s3 = c_ff.req_s2;
      nxt_c.cmp_s1 = cmp_in;
      nxt_c.cmp_s2 = c_ff.cmp_s1;
      req = c_ff.req_s2 ^ c_ff.req_s3;
      unique case (c_ff.st)
         CS_IDLE: begin
            if (req || c_ff.pend) begin
               nxt_c.st   = CS_ACQ;
               nxt_c.cnt  = 6'h00;
               nxt_c.pend = 1'b0;
            end
         end
         CS_ACQ: begin
            if (req) begin
               nxt_c.pend = 1'b1;
            end
            nxt_c.cnt = c_ff.cnt + 6'h01;
            if (c_ff.cnt == 6'(`SAR_ACQ_CYC - 1)) begin
               nxt_c.st   = CS_CONV;
               nxt_c.cnt  = 6'h00;
               nxt_c.bitn = 4'(`SAR_RES_W - 1);
               nxt_c.sar  = 10'h200;
            end
         end
         CS_CONV: begin
            if (req) begin
               nxt_c.pend = 1'b1;
            end
            nxt_c.cnt = c_ff.cnt + 6'h01;
            if (c_ff.cnt == 6'(`SAR_BIT_CYC - 1)) begin
               nxt_c.cnt = 6'h00;
               // The comparator is high when the input is above the trial.
               nxt_c.sar[c_ff.bitn] = c_ff.cmp_s2;
               if (c_ff.bitn == 4'h0) begin
                  nxt_c.result   = nxt_c.sar;
                  nxt_c.done_tgl = ~c_ff.done_tgl;
                  nxt_c.st       = CS_IDLE;
               end else begin
                  nxt_c.bitn = c_ff.bitn - 4'h1;
                  nxt_c.sar[c_ff.bitn - 4'h1] = 1'b1;
               end
            end
         end
      endcase
   end

   // Sequencer register.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         c_ff <= '{st: CS_IDLE, default: '0};
      end else begin
         c_ff <= nxt_c;
      end
   end

   assign afe = '{track: (c_ff.st == CS_ACQ), dac: c_ff.sar};

   // Slave: oversamples both wires, and drives the data wire only low.
   // The result word crosses by toggle; it stays still for a whole
   // conversion after each toggle, so sampling it then is safe.
   always_comb begin
      logic scl;
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic match;
      logic mid;
      scl   = 1'b0;
      rise  = 1'b0;
      fall  = 1'b0;
      start = 1'b0;
      stop  = 1'b0;
      match = 1'b0;
      mid   = 1'b0;
      nxt_l = l_ff;
      nxt_l.scl_s1 = scl_i;
      nxt_l.scl_s2 = l_ff.scl_s1;
      nxt_l.scl_s3 = l_ff.scl_s2;
      nxt_l.sda_s1 = sda_i;
      nxt_l.sda_s2 = l_ff.sda_s1;
      nxt_l.sda_s3 = l_ff.sda_s2;
      nxt_l.dn_s1  = c_ff.done_tgl;
      nxt_l.dn_s2  = l_ff.dn_s1;
      nxt_l.dn_s3  = l_ff.dn_s2;
      scl   = l_ff.scl_s2;
      rise  = scl && !l_ff.scl_s3;
      fall  = !scl && l_ff.scl_s3;
      start = scl && l_ff.scl_s3 && !l_ff.sda_s2 && l_ff.sda_s3;
      stop  = scl && l_ff.scl_s3 && l_ff.sda_s2 && !l_ff.sda_s3;
      match = (l_ff.sh[7:1] == {DEV_CODE, DEV_ADDR});
      // Between the two bytes of one word the copy waits, so that both
      // bytes come from the same conversion, unless the copy lands in the
      // very cycle that loads the upper byte.
      mid   = l_ff.rw &&
              ((!l_ff.byte1 && (l_ff.st == LS_TX || l_ff.st == LS_MACK)) ||
               (l_ff.byte1 && l_ff.st == LS_AACK));
      if (mid) begin
         // Holding the last stage keeps the toggle edge pending.
         nxt_l.dn_s3 = l_ff.dn_s3;
      end else if (l_ff.dn_s2 ^ l_ff.dn_s3) begin
         nxt_l.res = c_ff.result;
      end
      if (start) begin
         nxt_l.st   = LS_ADDR;
         nxt_l.cnt  = 4'h0;
         nxt_l.oe_n = 1'b1;
      end else if (stop) begin
         nxt_l.st   = LS_IDLE;
         nxt_l.oe_n = 1'b1;
      end else begin
         unique case (l_ff.st)
            LS_IDLE, LS_WAIT: begin
               nxt_l.oe_n = 1'b1;
            end
            LS_ADDR: begin
               if (rise) begin
                  nxt_l.sh  = {l_ff.sh[6:0], l_ff.sda_s2};
                  nxt_l.cnt = l_ff.cnt + 4'h1;
               end else if (fall && l_ff.cnt == 4'h8) begin
                  if (match) begin
                     nxt_l.oe_n  = 1'b0;
                     nxt_l.rw    = l_ff.sh[`SAR_RW_POS];
                     nxt_l.byte1 = 1'b0;
                     nxt_l.st    = LS_AACK;
                     if (l_ff.sh[`SAR_RW_POS]) begin
                        nxt_l.req_tgl = ~l_ff.req_tgl;
                     end
                  end else begin
                     nxt_l.st = LS_WAIT;
                  end
               end
            end
            LS_AACK: begin
               if (fall) begin
                  if (l_ff.rw) begin
                     nxt_l.sh = l_ff.byte1 ? {l_ff.res[5:0], 2'b00}
                                : {`SAR_PAD_W'h0, l_ff.res[9:6]};
                     nxt_l.oe_n = nxt_l.sh[7];
                     nxt_l.cnt  = 4'h0;
                     nxt_l.st   = LS_TX;
                  end else begin
                     nxt_l.oe_n = 1'b1;
                     nxt_l.st   = LS_WAIT;
                  end
               end
            end
            LS_TX: begin
               if (fall) begin
                  if (l_ff.cnt == 4'h7) begin
                     nxt_l.oe_n = 1'b1;
                     nxt_l.st   = LS_MACK;
                     if (l_ff.byte1) begin
                        nxt_l.req_tgl = ~l_ff.req_tgl;
                     end
                  end else begin
                     nxt_l.oe_n = l_ff.sh[6];
                     nxt_l.sh   = {l_ff.sh[6:0], 1'b0};
                     nxt_l.cnt  = l_ff.cnt + 4'h1;
                  end
               end
            end
            LS_MACK: begin
               if (rise) begin
                  if (l_ff.sda_s2) begin
                     nxt_l.st = LS_WAIT;
                  end else begin
                     nxt_l.byte1 = ~l_ff.byte1;
                     nxt_l.st    = LS_AACK;
                  end
               end
            end
            default: begin
               nxt_l.st = LS_IDLE;
            end
         endcase
      end
   end

   // Slave register.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         // Pin stages start at the idle wire level: no false edge later.
         l_ff <= '{st: LS_IDLE, oe_n: 1'b1,
                   scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
                   sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
                   default: '0};
      end else begin
         l_ff <= nxt_l;
      end
   end

   // The wire is only ever pulled low; the enable carries the data.
   assign sda_o    = 1'b0;
   assign sda_oe_n = l_ff.oe_n;

   // An 18-clock frame at 400 kHz outlasts ACQ_C + CONV_C, but the next upper byte loads
   // one clock after the request, so the master must stretch that ack clock high.

   a_drive_clk_low: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      $fell(l_ff.oe_n) |-> !l_ff.scl_s3)
      else $error("Data line pulled while clock high.");

   a_start_addr: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      (l_ff.scl_s2 && l_ff.scl_s3 && !l_ff.sda_s2 && l_ff.sda_s3)
      |=> (l_ff.st == LS_ADDR) && (l_ff.cnt == 4'h0))
      else $error("Start condition not taken.");

   a_result_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $changed(c_ff.result) |-> $changed(c_ff.done_tgl))
      else $error("Result changed without a finished conversion.");

   a_acq_len: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(afe.track) |-> afe.track[*8] ##ACQ_TAIL !afe.track)
      else $error("Acquisition length wrong.");

   a_conv_len: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $fell(afe.track) |-> ##[CONV_C:CONV_C] $changed(c_ff.done_tgl))
      else $error("Conversion length wrong.");

   sequence s_read_match;
      l_ff.st == LS_ADDR && !l_ff.scl_s2 && l_ff.scl_s3 &&
      l_ff.cnt == 4'h8 && l_ff.sh[7:1] == {DEV_CODE, DEV_ADDR};
   endsequence

   a_read_start: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      s_read_match ##0 l_ff.sh[0]
      |=> !l_ff.oe_n && $changed(l_ff.req_tgl))
      else $error("Read address not acknowledged or no request.");

   a_addr_ignore: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      (l_ff.st == LS_ADDR && !l_ff.scl_s2 && l_ff.scl_s3 &&
       l_ff.cnt == 4'h8 && l_ff.sh[7:1] != {DEV_CODE, DEV_ADDR})
      |=> l_ff.oe_n && l_ff.st == LS_WAIT)
      else $error("Foreign address acknowledged.");

   a_poll_release: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      (l_ff.st == LS_AACK && !l_ff.rw && !l_ff.scl_s2 && l_ff.scl_s3)
      |=> l_ff.oe_n && l_ff.st == LS_WAIT)
      else $error("Bus not released after write address.");

   a_lead_zero: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      (l_ff.st == LS_AACK && l_ff.rw && !l_ff.byte1 &&
       !l_ff.scl_s2 && l_ff.scl_s3) |=> !l_ff.oe_n && l_ff.st == LS_TX)
      else $error("Upper byte does not open with zero.");

   a_next_sample: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      (l_ff.st == LS_TX && l_ff.byte1 && l_ff.cnt == 4'h7 &&
       !l_ff.scl_s2 && l_ff.scl_s3) |=> $changed(l_ff.req_tgl))
      else $error("Next sample not requested on last bit.");

endmodule

// File: verif/sar_mst_model.sv
// Behavioural two-wire bus master that drives the converter's serial pins.
// Assumes pull-ups on both wires; all timing counts are cycles of clk.
`timescale 1ns/1ps

module sar_mst_model (
   input  wire logic clk,
   input  wire logic sda_i,
   output logic      scl,
   output logic      sda_m
);
   // Both wires start released, so the bus reads idle before any frame.
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   // Waits n cycles and lands just after the edge.
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One bit; a long high phase lets a conversion finish before the load.
   // data moves only with clock low
   task automatic bit_x(input logic d, input int hi, output logic q);
      sda_m = d;
      wt(25);
      scl = 1'b1;
      wt(hi);
      q = sda_i;
      scl = 1'b0;
      wt(25);
   endtask

   // start: data falls while clock high
   task automatic start();
      sda_m = 1'b1;
      wt(25);
      sda_m = 1'b0;
      wt(25);
      scl = 1'b0;
      wt(25);
   endtask

   // stop: data rises while clock high
   task automatic stop();
      sda_m = 1'b0;
      wt(25);
      scl = 1'b1;
      wt(25);
      sda_m = 1'b1;
      wt(50);
   endtask

   // Sends the address byte MSB first and returns the device's answer.
   task automatic wr_byte(input logic [7:0] b, input int hi,
                          output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], 50, q);
      end
      bit_x(1'b1, hi, ack);
   endtask

   // Reads one byte; the master's answer bit follows.
   // master ack continues, nack ends
   task automatic rd_byte(input logic ack_n, input int hi,
                          output logic [7:0] b);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, 50, b[i]);
      end
      bit_x(ack_n, hi, q);
   endtask
endmodule

// File: verif/sar_adc_i2c_readout_tb_top.sv
// Self-checking bench for the converter control block and its slave port.
// Assumes the package is compiled first; the comparator is modelled here.
`timescale 1ns/1ps

module sar_adc_i2c_readout_tb_top;
   import sar_pkg::*;

   logic       core_clk;  // Sequencer clock, 25 ns.
   logic       link_clk;  // Slave oversampling clock, 12 ns.
   logic       rst_n;     // Active-low reset.
   logic       scl;       // Clock wire from the master.
   logic       sda_m;     // Master's data drive, 1 = released.
   logic       sda_o;     // Device data drive value.
   logic       sda_oe_n;  // Device data enable, low = pulling.
   wire logic  sda;       // Resolved data wire with pull-up.
   logic [9:0] ain;       // Input level as an ideal code.
   sar_afe_t   afe;       // Track switch and trial code.
   int         error_cnt;
   int         compares;
   logic       ack;
   logic [7:0] b;

   // Wired-AND of both parties over the pull-up.
   assign sda = sda_m & (sda_oe_n | sda_o);

   // Ideal comparator: keeps the trial bit when the input is not below it.
   wire logic cmp = (ain >= afe.dac);

   initial core_clk = 1'b0;
   initial link_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;
   always #6 link_clk = ~link_clk;

   sar_adc_i2c_readout #(
      .DEV_CODE (4'h5),
      .DEV_ADDR (3'h0)
   ) u_sar_adc_i2c_readout (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .link_clk (link_clk),
      .scl_i    (scl),
      .sda_i    (sda),
      .sda_o    (sda_o),
      .sda_oe_n (sda_oe_n),
      .cmp_in   (cmp),
      .afe      (afe)
   );

   sar_mst_model u_sar_mst_model (
      .clk   (core_clk),
      .sda_i (sda),
      .scl   (scl),
      .sda_m (sda_m)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // The device may only move the data wire while the clock is low.
   always @(sda_oe_n) begin
      if (rst_n === 1'b1) begin
         check(16'(scl), 16'h0000);
      end
   end

   // Times the track pulse and the decided code of one conversion.
   task automatic t_measure(input logic [9:0] v);
      int n;
      n = 0;
      while (afe.track !== 1'b1 && n < 2000) begin
         wt(1);
         n++;
      end
      if (n == 2000) begin
         error_cnt++;
         finish_test();
      end
      n = 0;
      while (afe.track === 1'b1 && n < 200) begin
         wt(1);
         n++;
      end
      check(16'(n), 16'h002d);
      wt(355);
      check(16'(afe.dac), 16'(v));
   endtask

   // An address that differs only in its address bits is ignored.
   task automatic t_nomatch();
      u_sar_mst_model.start();
      u_sar_mst_model.wr_byte(8'h53, 480, ack);
      check(16'(ack), 16'h0001);
      check(16'(afe.track), 16'h0000);
      u_sar_mst_model.stop();
   endtask

   // A write address is answered, then the bus is left released.
   task automatic t_poll();
      u_sar_mst_model.start();
      u_sar_mst_model.wr_byte(8'h50, 480, ack);
      check(16'(ack), 16'h0000);
      check(16'(afe.track), 16'h0000);
      u_sar_mst_model.rd_byte(1'b1, 50, b);
      check(16'(b), 16'h00ff);
      u_sar_mst_model.stop();
   endtask

   // Single read: the held result of this frame's sample, MSB first.
   task automatic t_single(input logic [9:0] v);
      ain = v;
      u_sar_mst_model.start();
      fork
         u_sar_mst_model.wr_byte(8'h51, 480, ack);
         t_measure(v);
      join
      check(16'(ack), 16'h0000);
      u_sar_mst_model.rd_byte(1'b0, 50, b);
      check(16'(b), 16'({4'h0, v[9:6]}));
      u_sar_mst_model.rd_byte(1'b1, 50, b);
      check(16'(b), 16'({v[5:0], 2'b00}));
      u_sar_mst_model.stop();
   endtask

   // Continuous mode: ack after a pair brings the next sample unaddressed.
   task automatic t_cont(input logic [9:0] v1, input logic [9:0] v2);
      ain = v1;
      u_sar_mst_model.start();
      u_sar_mst_model.wr_byte(8'h51, 480, ack);
      u_sar_mst_model.rd_byte(1'b0, 50, b);
      check(16'(b), 16'({4'h0, v1[9:6]}));
      ain = v2;
      u_sar_mst_model.rd_byte(1'b0, 480, b);
      check(16'(b), 16'({v1[5:0], 2'b00}));
      u_sar_mst_model.rd_byte(1'b0, 50, b);
      check(16'(b), 16'({4'h0, v2[9:6]}));
      u_sar_mst_model.rd_byte(1'b1, 50, b);
      check(16'(b), 16'({v2[5:0], 2'b00}));
      u_sar_mst_model.stop();
   endtask

   initial begin
      error_cnt = 0;
      compares  = 0;
      ain       = 10'h000;
      rst_n     = 1'b0;
      wt(10);
      check(16'(sda_oe_n), 16'h0001);
      check(16'(sda_o), 16'h0000);
      check(16'(afe), 16'h0000);
      rst_n = 1'b1;
      wt(20);
      t_nomatch();
      t_poll();
      t_single(10'h2b5);
      t_cont(10'h3ff, 10'h000);
      t_single(10'h001);
      finish_test();
   end
endmodule
